// *** hw/rrsa_cores.sv ***
`timescale 1ns/1ns
`include "rrsa_defines.svh"
module rrsa_cores
   import rrsa_pkg::*;
#(
   parameter int NCORE = `RRSA_NCORE,
   parameter int NPIN = `RRSA_NPIN,
   parameter int CNT_W = `RRSA_CNT_W
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Hub side
   rrsa_if.cores bus,
   // User side, one lane per core for ops and pin drivers; pin inputs and counter are shared
   input wire logic [NCORE-1:0] op_start_i,
   output logic [NCORE-1:0] op_done_o,
   output logic [NCORE-1:0] op_wait_o,
   input wire logic [NCORE*NPIN-1:0] io_dir_i,
   input wire logic [NCORE*NPIN-1:0] io_out_i,
   output logic [NPIN-1:0] io_in_o,
   output logic [CNT_W-1:0] sys_cnt_o
);

   logic [NCORE-1:0] req_reg;
   logic [NCORE-1:0] done_reg;
   logic [NCORE-1:0] wait_reg;
   logic [NPIN-1:0] io_in_reg;
   logic [CNT_W-1:0] cnt_reg;

   genvar k;
   generate
      for (k = 0; k < NCORE; k++)
      begin : g_core
         rrsa_core_e st_reg;
         rrsa_core_e st_next;
         // Request is held until the hub reports completion
         always_comb
         begin
            st_next = st_reg;
            unique case (st_reg)
               RRSA_CORE_IDLE:
               begin
                  if (op_start_i[k])
                  begin
                     st_next = RRSA_CORE_WAIT;
                  end
               end
               RRSA_CORE_WAIT:
               begin
                  if (bus.grant[k])
                  begin
                     st_next = RRSA_CORE_EXEC;
                  end
               end
               RRSA_CORE_EXEC:
               begin
                  if (bus.done[k])
                  begin
                     st_next = RRSA_CORE_IDLE;
                  end
               end
               default:
               begin
                  st_next = RRSA_CORE_IDLE;
               end
            endcase
         end

         always_ff @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               st_reg <= RRSA_CORE_IDLE;
               req_reg[k] <= 1'b0;
               done_reg[k] <= 1'b0;
               wait_reg[k] <= 1'b0;
            end
            else
            begin
               st_reg <= st_next;
               req_reg[k] <= (st_next != RRSA_CORE_IDLE) && !bus.done[k];
               done_reg[k] <= (st_reg == RRSA_CORE_EXEC) && bus.done[k];
               wait_reg[k] <= (st_next != RRSA_CORE_IDLE);
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         io_in_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         io_in_reg <= bus.io_in;
         cnt_reg <= bus.sys_cnt;
      end
   end

   assign bus.req = req_reg;
   assign bus.io_dir = io_dir_i;
   assign bus.io_out = io_out_i;
   assign op_done_o = done_reg;
   assign op_wait_o = wait_reg;
   assign io_in_o = io_in_reg;
   assign sys_cnt_o = cnt_reg;

endmodule : rrsa_cores

// *** hw/rrsa_hub.sv ***
`timescale 1ns/1ns
`include "rrsa_defines.svh"
// Summary of operation
// - Turns rotate core zero to seven, wrap
// - Arbiter advances at half system clock
// - One window per core every sixteen clocks
// - Shared op aligns to window, runs seven
// - Late request waits up to fifteen clocks
// - Total latency seven to twenty-two clocks
// - Nine spare clocks after op completes
// - Next core window two clocks later
// - Cores never stall one another
// - One core granted at a time, arbiter free-running
// - Pins and counter bypass the arbiter
// - Eight identical cores, one clock
// - Clock source selectable at run time
module rrsa_hub
   import rrsa_pkg::*;
#(
   parameter int NCORE = `RRSA_NCORE,
   parameter int NPIN = `RRSA_NPIN,
   parameter int CNT_W = `RRSA_CNT_W
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Core side
   rrsa_if.hub bus,
   // Clock source selection
   input wire logic [1:0] clk_src_sel_i,
   input wire logic clk_src_wr_i,
   output logic [1:0] clk_src_o,
   output logic clk_src_err_o,
   // Common pins
   input wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0] pin_o,
   output logic [NPIN-1:0] pin_oe_n_o,
   // Status
   output logic [2:0] slot_o,
   output logic [NCORE-1:0] busy_o
);

   localparam logic [2:0] EXEC_LOAD = 3'(`RRSA_EXEC_CLKS);
   localparam logic [3:0] PHASE_LAST = 4'(`RRSA_ROT_CLKS - 1);

   // System clock phase within one rotation
   logic [3:0] phase_reg;
   logic [3:0] phase_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [NCORE-1:0] grant_reg;
   logic [NCORE-1:0] done_reg;
   logic [2:0] slot_reg;
   logic [NCORE-1:0] busy_reg;
   logic [1:0] clk_src_reg;
   logic clk_src_err_reg;
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_sync_reg;
   logic [NPIN-1:0] pin_out_reg;
   logic [NPIN-1:0] pin_oe_n_reg;
   wire [NCORE-1:0] win_open;
   wire [NCORE-1:0] grant_next;
   wire [NCORE-1:0] done_next;
   wire [NPIN-1:0] dir_any;
   wire [NPIN-1:0] out_any;
   wire src_legal;

   assign phase_next = (phase_reg == PHASE_LAST) ? 4'h0 : phase_reg + 4'h1;
   assign cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};

   // Window for core k opens at phase 2k
   genvar k;
   generate
      for (k = 0; k < NCORE; k++)
      begin : g_core
         logic [2:0] exec_reg;
         logic [2:0] exec_next;
         wire exec_busy;
         assign win_open[k] = (phase_reg == 4'(k * `RRSA_SLOT_CLKS));
         assign exec_busy = (exec_reg != 3'h0);
         // Only the owner of the slot may start; idle slots stay idle
         assign grant_next[k] = win_open[k] & bus.req[k] & ~exec_busy;
         assign done_next[k] = (exec_reg == 3'h1);
         assign exec_next = grant_next[k] ? EXEC_LOAD :
                            exec_busy ? exec_reg - 3'h1 : 3'h0;

         always_ff @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               exec_reg <= 3'h0;
               busy_reg[k] <= 1'b0;
            end
            else
            begin
               exec_reg <= exec_next;
               busy_reg[k] <= (exec_next != 3'h0);
            end
         end
      end
   endgenerate

   // Wired-OR merge of per-core pin drivers
   generate
      for (k = 0; k < NPIN; k++)
      begin : g_pin
         logic [NCORE-1:0] dir_col;
         logic [NCORE-1:0] out_col;
         genvar c;
         for (c = 0; c < NCORE; c++)
         begin : g_col
            assign dir_col[c] = bus.io_dir[c*NPIN+k];
            assign out_col[c] = bus.io_out[c*NPIN+k] & bus.io_dir[c*NPIN+k];
         end
         assign dir_any[k] = |dir_col;
         assign out_any[k] = |out_col;
      end
   endgenerate

   assign src_legal = (clk_src_sel_i == RRSA_SRC_RC) ||
                      (clk_src_sel_i == RRSA_SRC_XTAL) ||
                      (clk_src_sel_i == RRSA_SRC_PLL);

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         phase_reg <= `RRSA_PHASE_RST;
         slot_reg <= 3'h0;
         cnt_reg <= '0;
         grant_reg <= '0;
         done_reg <= '0;
      end
      else
      begin
         phase_reg <= phase_next;
         slot_reg <= phase_next[3:1];
         cnt_reg <= cnt_next;
         grant_reg <= grant_next;
         done_reg <= done_next;
      end
   end

   // Clock source register, illegal codes are refused
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         clk_src_reg <= `RRSA_CLKSRC_RST;
         clk_src_err_reg <= 1'b0;
      end
      else if (clk_src_wr_i)
      begin
         if (src_legal)
         begin
            clk_src_reg <= clk_src_sel_i;
         end
         clk_src_err_reg <= ~src_legal;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_out_reg <= '0;
         pin_oe_n_reg <= '1;
      end
      else
      begin
         pin_meta_reg <= pin_i;
         pin_sync_reg <= pin_meta_reg;
         pin_out_reg <= out_any;
         pin_oe_n_reg <= ~dir_any;
      end
   end

   assign bus.grant = grant_reg;
   assign bus.done = done_reg;
   assign bus.slot = slot_reg;
   assign bus.io_in = pin_sync_reg;
   assign bus.sys_cnt = cnt_reg;
   assign clk_src_o = clk_src_reg;
   assign clk_src_err_o = clk_src_err_reg;
   assign pin_o = pin_out_reg;
   assign pin_oe_n_o = pin_oe_n_reg;
   assign slot_o = slot_reg;
   assign busy_o = busy_reg;

endmodule : rrsa_hub

// *** inc/rrsa_defines.svh ***
`ifndef RRSA_DEFINES_SVH
`define RRSA_DEFINES_SVH

// Sizes of the core array and the common pins
`define RRSA_NCORE 8
`define RRSA_NPIN 32
`define RRSA_CNT_W 32

// System clock period in ns
`define RRSA_CLK_PERIOD_NS 10

// Arbiter timing in system clocks
`define RRSA_HUB_DIV 2
`define RRSA_SLOT_CLKS (`RRSA_HUB_DIV)
`define RRSA_ROT_CLKS (`RRSA_SLOT_CLKS * `RRSA_NCORE)
`define RRSA_EXEC_CLKS 7
`define RRSA_MAX_WAIT_CLKS (`RRSA_ROT_CLKS - 1)
`define RRSA_MAX_LAT_CLKS (`RRSA_MAX_WAIT_CLKS + `RRSA_EXEC_CLKS)
`define RRSA_SPARE_CLKS (`RRSA_ROT_CLKS - `RRSA_EXEC_CLKS)

// Reset values
`define RRSA_PHASE_RST 4'h0
`define RRSA_CLKSRC_RST 2'h0

`endif

// *** inc/rrsa_if.sv ***
`timescale 1ns/1ns
`include "rrsa_defines.svh"

interface rrsa_if
#(
   parameter int NCORE = `RRSA_NCORE,
   parameter int NPIN = `RRSA_NPIN,
   parameter int CNT_W = `RRSA_CNT_W
);
   // Shared-access handshake, one bit per core, plus the current slot number
   logic [NCORE-1:0] req;
   logic [NCORE-1:0] grant;
   logic [NCORE-1:0] done;
   logic [2:0] slot;
   // Common resources
   logic [NCORE*NPIN-1:0] io_dir;
   logic [NCORE*NPIN-1:0] io_out;
   logic [NPIN-1:0] io_in;
   logic [CNT_W-1:0] sys_cnt;

   modport hub
   (
      input req,
      input io_dir,
      input io_out,
      output grant,
      output done,
      output slot,
      output io_in,
      output sys_cnt
   );

   modport cores
   (
      output req,
      output io_dir,
      output io_out,
      input grant,
      input done,
      input slot,
      input io_in,
      input sys_cnt
   );
endinterface : rrsa_if

// *** inc/rrsa_pkg.sv ***
package rrsa_pkg;

   // System clock source selection
   typedef enum logic [1:0]
   {
      RRSA_SRC_RC = 2'b00,
      RRSA_SRC_XTAL = 2'b01,
      RRSA_SRC_PLL = 2'b10
   } rrsa_clksrc_e;

   // Per-core shared-access sequence
   typedef enum logic [1:0]
   {
      RRSA_CORE_IDLE = 2'b00,
      RRSA_CORE_WAIT = 2'b01,
      RRSA_CORE_EXEC = 2'b10
   } rrsa_core_e;

   typedef logic [2:0] rrsa_core_id_t;

endpackage : rrsa_pkg

// *** test/round_robin_shared_access_arbiter_tb.sv ***
`timescale 1ns/1ns
`include "rrsa_defines.svh"
module round_robin_shared_access_arbiter_tb
   import rrsa_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [1:0] src_sel = 2'h0;
   logic src_wr = 1'b0;
   logic [31:0] pins = 32'h0;
   logic [7:0] start = 8'h0;
   logic [255:0] dir = '0;
   logic [255:0] dout = '0;
   logic [1:0] src_o;
   logic src_err;
   logic [31:0] pin_o, pin_oe_n, io_in, cnt, c0, eo, ed;
   logic [2:0] slot_o;
   logic [7:0] busy, op_done, op_wait;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   int base = 0;
   int bc[8];
   int lo = 99;
   int hi = 0;
   int lat[8];

   rrsa_if bus_if ();
   rrsa_hub rrsa_hub_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus_if),
      .clk_src_sel_i(src_sel), .clk_src_wr_i(src_wr), .clk_src_o(src_o),
      .clk_src_err_o(src_err), .pin_i(pins), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n),
      .slot_o(slot_o), .busy_o(busy));
   rrsa_cores rrsa_cores_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus_if),
      .op_start_i(start), .op_done_o(op_done), .op_wait_o(op_wait), .io_dir_i(dir),
      .io_out_i(dout), .io_in_o(io_in), .sys_cnt_o(cnt));
   rrsa_props rrsa_props_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .req(bus_if.req),
      .grant(bus_if.grant), .done(bus_if.done), .slot(bus_if.slot));

   always #5 mclk_i = ~mclk_i;

   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         failures++;
         complete_run();
      end
   end

   task tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Slot from clock edges counted since reset release
   function automatic logic [31:0] exp_slot();
      return 32'(((cyc - base) % `RRSA_ROT_CLKS) / `RRSA_SLOT_CLKS);
   endfunction : exp_slot

   // Per-core cycles from start edge to done pulse
   task run_ops(input logic [7:0] m);
      int n;
      start = m;
      tick(1);
      start = 8'h0;
      chk(32'(op_wait), 32'(m));
      lat = '{default: 0};
      bc = '{default: 0};
      for (n = 0; n < 30; n++)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (op_done[i] === 1'b1)
               lat[i] = n;
            if (busy[i] === 1'b1)
               bc[i]++;
         end
         chk(32'(slot_o), exp_slot());
         tick(1);
      end
      for (int i = 0; i < 8; i++)
         chk(bc[i], m[i] ? `RRSA_EXEC_CLKS : 0);
   endtask : run_ops

   // First count checked when first is positive; gap idles before restart
   task b2b(input int k, input int gap, input int first);
      int n;
      start[k] = 1'b1;
      tick(1);
      start[k] = 1'b0;
      for (n = 0; n < 30 && op_done[k] !== 1'b1; n++)
         tick(1);
      if (first > 0)
         chk(n, first);
      if (gap > 0)
         tick(gap);
      start[k] = 1'b1;
      tick(1);
      start[k] = 1'b0;
      for (n = 1; n < 40 && op_done[k] !== 1'b1; n++)
         tick(1);
      chk(n, `RRSA_ROT_CLKS - gap);
   endtask : b2b

   task complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      void'($urandom(94027));
      tick(2);
      rstn_i = 1'b1;
      base = cyc;
      src_wr = 1'b1;
      for (int c = 3; c >= 0; c--)
      begin
         src_sel = 2'(c);
         tick(1);
         chk(32'(src_o), (c == 3) ? 0 : c);
         chk(32'(src_err), 32'(c == 3));
      end
      src_wr = 1'b0;
      repeat (6)
      begin
         for (int i = 0; i < 256; i += 32)
         begin
            dir[i+:32] = $urandom;
            dout[i+:32] = $urandom;
         end
         pins = $urandom;
         tick(3);
         eo = 32'h0;
         ed = 32'h0;
         for (int i = 0; i < 256; i += 32)
         begin
            eo |= dir[i+:32] & dout[i+:32];
            ed |= dir[i+:32];
         end
         chk(pin_o, eo);
         chk(pin_oe_n, ~ed);
         chk(io_in, pins);
      end
      c0 = cnt;
      tick(10);
      chk(cnt - c0, 32'hA);
      // Start phase slips by 15 each pass, so all 16 are met
      repeat (16)
      begin
         run_ops(8'($urandom) | 8'h01);
         lo = (lat[0] < lo) ? lat[0] : lo;
         hi = (lat[0] > hi) ? lat[0] : hi;
      end
      chk(hi - lo, 15);
      chk(lo, `RRSA_EXEC_CLKS + 2);
      chk(hi, `RRSA_MAX_LAT_CLKS + 2);
      repeat (3)
      begin
         tick($urandom_range(1, 16));
         run_ops(8'hFF);
         for (int k = 0; k < 8; k++)
            chk((lat[(k + 1) % 8] - lat[k] + 16) % 16, 2);
      end
      b2b(3, 0, 0);
      b2b(5, 6, 0);
      rstn_i = 1'b0;
      tick(2);
      rstn_i = 1'b1;
      base = cyc;
      b2b(0, 0, `RRSA_MAX_LAT_CLKS + 2);
      complete_run();
   end
endmodule : round_robin_shared_access_arbiter_tb

// *** test/rrsa_props.sv ***
`timescale 1ns/1ns
module rrsa_props
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [7:0] req,
   input wire logic [7:0] grant,
   input wire logic [7:0] done,
   input wire logic [2:0] slot
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // Rest of a core zero rotation
   sequence quiet_g0_s;
      (!grant[0])[*8] ##1 (!grant[0])[*7];
   endsequence
   one_grant_a: assert property ($onehot0(grant)) else $error("two grants");
   grant_slot_a: assert property (grant != 0 |-> grant == (8'h01 << $past(slot)))
      else $error("grant off slot");
   slot_step_a: assert property ($changed(slot) |-> slot == 3'($past(slot) + 3'h1))
      else $error("slot skipped");
   slot_hold_a: assert property ($changed(slot) |=> $stable(slot)) else $error("slot fast");
   grant_gap_a: assert property (grant != 0 |=> grant == 8'h00) else $error("grant gap");
   grant_req_a: assert property (grant != 0 |-> ($past(req) & grant) == grant)
      else $error("grant without req");
   window_period_a: assert property (grant[0] |=> quiet_g0_s) else $error("early window");
   done_seven_a: assert property (grant != 0 |-> ##7 done == $past(grant, 7))
      else $error("done late");
   done_cause_a: assert property (done != 0 |-> done == $past(grant, 7))
      else $error("stray done");
endmodule : rrsa_props
